// File: inc/gptu_pkg.sv
// Constants shared by the general purpose timer unit.
package gptu_pkg;
	localparam int GPTU_W = 16;
	localparam int GPTU_NT = 5;
	localparam int GPTU_PRE_W = 10;
	// Timer indices.
	localparam int IDX_AUX_LOW = 0;
	localparam int IDX_CORE_FIRST = 1;
	localparam int IDX_AUX_HIGH = 2;
	localparam int IDX_AUX_SECOND = 3;
	localparam int IDX_CORE_SECOND = 4;
	localparam int FIRST_MODULE_COUNT = 3;
	// Prescaler base shifts: first module 8 (2^3), second module 4 (2^2).
	localparam logic [3:0] FIRST_PRE_SHIFT = 4'h3;
	localparam logic [3:0] SECOND_PRE_SHIFT = 4'h2;
	// Byte offsets of the APB registers.
	localparam logic [7:0] OFF_CTRL_BASE = 8'h00;
	localparam logic [7:0] OFF_CNT_BASE = 8'h20;
	localparam logic [7:0] OFF_CAPTURE_RELOAD = 8'h40;
	localparam logic [7:0] OFF_CAPCFG = 8'h44;
	localparam logic [7:0] OFF_STATUS = 8'h48;
	// Timer control fields.
	localparam int F_PRE_LO = 0;
	localparam int F_MODE_LO = 3;
	localparam int F_RUN = 6;
	localparam int F_DOWN = 7;
	localparam int F_EXTDIR = 8;
	localparam int F_GATE_LOW = 9;
	localparam int F_EDGE_LO = 10;
	localparam int CTRL_W = 12;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
	// Capture configuration fields.
	localparam int C_EDGE_LO = 0;
	localparam int C_CLEAR = 2;
	localparam int C_TRIG_CNT = 3;
	localparam int C_TRIG_DIR = 4;
	localparam int C_RELOAD = 5;
	localparam int CFG_W = 6;
	localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
	typedef enum logic [2:0] {
		MODE_TIMER = 3'b000,
		MODE_COUNTER = 3'b001,
		MODE_GATED = 3'b010,
		MODE_INCR = 3'b011,
		MODE_RELOAD = 3'b100,
		MODE_CAPTURE = 3'b101,
		MODE_CONCAT = 3'b110
	} gptu_mode_t;
endpackage

// File: logic/gptu_timer.sv
// One 16-bit up/down timer cell with load and wrap detection.
`timescale 1ns/10ps
module gptu_timer #(
	parameter int WIDTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic up,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_val,
	output logic [WIDTH-1:0] value,
	output logic wrap
);
	logic [WIDTH-1:0] cnt_reg;

	// A count step that leaves all ones upward or zero downward wraps.
	// The wrap ignores load, since the reload it triggers drives load.
	// wrap detection
	assign wrap = tick &&
		(up ? (cnt_reg == {WIDTH{1'b1}}) : (cnt_reg == '0));
	assign value = cnt_reg;

	// Load takes priority over counting.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (tick) begin
			cnt_reg <= up ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
		end
	end

	a_wrap_to_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wrap && up && !load) |=> (cnt_reg == '0))
		else $error("Upward wrap did not reach zero.");
	a_wrap_to_ones: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wrap && !up && !load) |=> (cnt_reg == {WIDTH{1'b1}}))
		else $error("Downward wrap did not reach all ones.");
endmodule

// File: logic/gptu_unit.sv
// General purpose timer unit: two timer modules behind an APB slave.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
module gptu_unit #(
	parameter int NT = gptu_pkg::GPTU_NT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NT-1:0] count_gate_input_pin,
	input wire logic [NT-1:0] external_direction_pin,
	input wire logic capture_trigger_pin,
	output logic toggle_output_pin,
	output logic second_core_toggle_pin,
	output logic compare_clock_pulse
);
	import gptu_pkg::*;

	logic [CTRL_W-1:0] ctrl_reg [NT];
	logic [CFG_W-1:0] cfg_reg;
	logic [GPTU_W-1:0] capture_reload_register;
	logic [GPTU_PRE_W-1:0] pre_reg;
	logic output_toggle_latch, second_core_toggle_latch;
	logic tl_first_d_reg, tl_second_d_reg;
	logic [NT:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
	logic [NT-1:0] e1_reg, e2_reg, e3_reg, efilt_reg, efilt_d_reg;
	logic [NT-1:0] tick, up, load, wrap, wr_cnt;
	logic [GPTU_W-1:0] load_val [NT];
	logic [GPTU_W-1:0] cnt [NT];
	logic cap_ev;
	logic wr_en, setup;

	// Prescaler tick when the low shift bits of the divider are all ones.
	function automatic logic pre_tick(input logic [GPTU_PRE_W-1:0] c,
		input logic [3:0] sh);
		logic [GPTU_PRE_W-1:0] m;
		m = ~({GPTU_PRE_W{1'b1}} << sh);
		return (c & m) == m;
	endfunction

	// Edge select: bit 0 rising, bit 1 falling.
	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic [1:0] sel);
		return (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
	endfunction

	// Free running divider shared by all prescalers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// Pins pass three flops; a level is taken once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_reg <= '0;
			filt_d_reg <= '0;
			e1_reg <= '0;
			e2_reg <= '0;
			e3_reg <= '0;
			efilt_reg <= '0;
			efilt_d_reg <= '0;
		end else begin
			s1_reg <= {capture_trigger_pin, count_gate_input_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// Agreeing stages set the level; a disagreement holds it.
			filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) |
				(filt_reg & (s2_reg ^ s3_reg));
			filt_d_reg <= filt_reg;
			e1_reg <= external_direction_pin;
			e2_reg <= e1_reg;
			e3_reg <= e2_reg;
			efilt_reg <= (s3_eq(e2_reg, e3_reg) & e3_reg) |
				(~s3_eq(e2_reg, e3_reg) & efilt_reg);
			efilt_d_reg <= efilt_reg;
		end
	end

	function automatic logic [NT-1:0] s3_eq(input logic [NT-1:0] a,
		input logic [NT-1:0] b);
		return ~(a ^ b);
	endfunction

	// Per-timer clock source, direction and load selection.
	always_comb begin
		logic [CTRL_W-1:0] c;
		logic [3:0] sh;
		logic ev, a_ev, b_ev, tl_ev, gate;
		c = '0;
		sh = '0;
		ev = 1'b0;
		a_ev = 1'b0;
		b_ev = 1'b0;
		tl_ev = 1'b0;
		gate = 1'b0;
		for (int i = 0; i < NT; i++) begin
			c = ctrl_reg[i];
			sh = (i < FIRST_MODULE_COUNT ? FIRST_PRE_SHIFT : SECOND_PRE_SHIFT)
				+ {1'b0, c[F_PRE_LO +: 3]};
			ev = edge_hit(filt_d_reg[i], filt_reg[i], c[F_EDGE_LO +: 2]);
			a_ev = filt_d_reg[i] != filt_reg[i];
			b_ev = efilt_d_reg[i] != efilt_reg[i];
			tl_ev = (i < FIRST_MODULE_COUNT) ?
				(output_toggle_latch != tl_first_d_reg) :
				(second_core_toggle_latch != tl_second_d_reg);
			gate = filt_reg[i] ^ c[F_GATE_LOW];
			case (gptu_mode_t'(c[F_MODE_LO +: 3]))
				MODE_TIMER: tick[i] = pre_tick(pre_reg, sh);
				MODE_COUNTER: tick[i] = ev;
				MODE_GATED: tick[i] = pre_tick(pre_reg, sh) && gate;
				MODE_INCR: tick[i] = a_ev || b_ev;
				MODE_CONCAT: tick[i] = tl_ev && i != IDX_CORE_FIRST &&
					i != IDX_CORE_SECOND;
				default: tick[i] = 1'b0;
			endcase
			tick[i] = tick[i] && c[F_RUN];
			up[i] = !(c[F_DOWN] ^ (c[F_EXTDIR] && efilt_reg[i]));
			if (gptu_mode_t'(c[F_MODE_LO +: 3]) == MODE_INCR) begin
				up[i] = a_ev ? (filt_reg[i] != efilt_reg[i]) :
					(filt_reg[i] == efilt_reg[i]);
			end
			load[i] = wr_cnt[i];
			load_val[i] = pwdata[GPTU_W-1:0];
			// aux captures core on own pin edge
			if (!wr_cnt[i] && i < FIRST_MODULE_COUNT && i != IDX_CORE_FIRST &&
				gptu_mode_t'(c[F_MODE_LO +: 3]) == MODE_CAPTURE && ev) begin
				load[i] = 1'b1;
				load_val[i] = cnt[IDX_CORE_FIRST];
			end
		end
		if (!wr_cnt[IDX_CORE_FIRST] && wrap[IDX_CORE_FIRST]) begin
			if (gptu_mode_t'(ctrl_reg[IDX_AUX_LOW][F_MODE_LO +: 3]) ==
				MODE_RELOAD) begin
				load[IDX_CORE_FIRST] = 1'b1;
				load_val[IDX_CORE_FIRST] = cnt[IDX_AUX_LOW];
			end else if (gptu_mode_t'(ctrl_reg[IDX_AUX_HIGH][F_MODE_LO +: 3])
				== MODE_RELOAD) begin
				load[IDX_CORE_FIRST] = 1'b1;
				load_val[IDX_CORE_FIRST] = cnt[IDX_AUX_HIGH];
			end
		end
		// reload second core from capture register
		if (!wr_cnt[IDX_CORE_SECOND] && wrap[IDX_CORE_SECOND] &&
			cfg_reg[C_RELOAD]) begin
			load[IDX_CORE_SECOND] = 1'b1;
			load_val[IDX_CORE_SECOND] = capture_reload_register;
		end
		if (!wr_cnt[IDX_AUX_SECOND] && cap_ev && cfg_reg[C_CLEAR]) begin
			load[IDX_AUX_SECOND] = 1'b1;
			load_val[IDX_AUX_SECOND] = '0;
		end
	end

	assign cap_ev = edge_hit(filt_d_reg[NT], filt_reg[NT],
		cfg_reg[C_EDGE_LO +: 2]) ||
		(cfg_reg[C_TRIG_CNT] &&
		filt_d_reg[IDX_CORE_FIRST] != filt_reg[IDX_CORE_FIRST]) ||
		(cfg_reg[C_TRIG_DIR] &&
		efilt_d_reg[IDX_CORE_FIRST] != efilt_reg[IDX_CORE_FIRST]);

	genvar g;
	generate
		for (g = 0; g < NT; g++) begin : g_tmr
			gptu_timer #(.WIDTH(GPTU_W)) u_tmr (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick[g]),
				.up(up[g]),
				.load(load[g]),
				.load_val(load_val[g]),
				.value(cnt[g]),
				.wrap(wrap[g])
			);
		end
	endgenerate

	// Toggle latches, their delayed copies and the compare clock pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_toggle_latch <= 1'b0;
			second_core_toggle_latch <= 1'b0;
			tl_first_d_reg <= 1'b0;
			tl_second_d_reg <= 1'b0;
			toggle_output_pin <= 1'b0;
			second_core_toggle_pin <= 1'b0;
			compare_clock_pulse <= 1'b0;
		end else begin
			output_toggle_latch <= output_toggle_latch ^ wrap[IDX_CORE_FIRST];
			second_core_toggle_latch <= second_core_toggle_latch ^
				wrap[IDX_CORE_SECOND];
			tl_first_d_reg <= output_toggle_latch;
			tl_second_d_reg <= second_core_toggle_latch;
			toggle_output_pin <= output_toggle_latch ^ wrap[IDX_CORE_FIRST];
			second_core_toggle_pin <= second_core_toggle_latch ^
				wrap[IDX_CORE_SECOND];
			compare_clock_pulse <= wrap[IDX_CORE_SECOND];
		end
	end

	// copy aux timer into capture register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_reload_register <= '0;
		end else if (wr_en && paddr == OFF_CAPTURE_RELOAD) begin
			capture_reload_register <= pwdata[GPTU_W-1:0];
		end else if (cap_ev) begin
			capture_reload_register <= cnt[IDX_AUX_SECOND];
		end
	end

	// APB decode: zero wait states, unmapped access flagged.
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	always_comb begin
		for (int i = 0; i < NT; i++) begin
			wr_cnt[i] = wr_en && paddr == OFF_CNT_BASE + 8'(4 * i);
		end
	end

	function automatic logic mapped(input logic [7:0] a);
		return (a < OFF_CTRL_BASE + 8'(4 * NT) && a[1:0] == 2'b00) ||
			(a >= OFF_CNT_BASE && a < OFF_CNT_BASE + 8'(4 * NT) &&
			a[1:0] == 2'b00) || a == OFF_CAPTURE_RELOAD ||
			a == OFF_CAPCFG ||
			a == OFF_STATUS;
	endfunction

	// Control and configuration writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NT; i++) begin
				ctrl_reg[i] <= CTRL_RESET;
			end
			cfg_reg <= CFG_RESET;
		end else if (wr_en) begin
			for (int i = 0; i < NT; i++) begin
				if (paddr == OFF_CTRL_BASE + 8'(4 * i)) begin
					ctrl_reg[i] <= pwdata[CTRL_W-1:0];
				end
			end
			if (paddr == OFF_CAPCFG) begin
				cfg_reg <= pwdata[CFG_W-1:0];
			end
		end
	end

	// Read data and error are set up in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				pslverr <= !mapped(paddr);
				prdata <= '0;
				for (int i = 0; i < NT; i++) begin
					if (paddr == OFF_CTRL_BASE + 8'(4 * i)) begin
						prdata <= {20'h00000, ctrl_reg[i]};
					end
					if (paddr == OFF_CNT_BASE + 8'(4 * i)) begin
						prdata <= {16'h0000, cnt[i]};
					end
				end
				if (paddr == OFF_CAPTURE_RELOAD) begin
					prdata <= {16'h0000, capture_reload_register};
				end
				if (paddr == OFF_CAPCFG) begin
					prdata <= {26'h0000000, cfg_reg};
				end
				if (paddr == OFF_STATUS) begin
					prdata <= {30'h00000000, second_core_toggle_latch,
						output_toggle_latch};
				end
			end
		end
	end

	sequence s_core2_wrap;
		wrap[IDX_CORE_SECOND] && cfg_reg[C_RELOAD] &&
			!wr_cnt[IDX_CORE_SECOND];
	endsequence
	sequence s_reloaded;
		cnt[IDX_CORE_SECOND] == $past(capture_reload_register);
	endsequence

	a_toggle_first_core: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap[IDX_CORE_FIRST] |=>
		output_toggle_latch != $past(output_toggle_latch))
		else $error("First toggle latch missed a wrap.");
	a_toggle_second_core: assert property (
		@(posedge pclk) disable iff (!presetn)
		!wrap[IDX_CORE_SECOND] |=>
		second_core_toggle_latch == $past(second_core_toggle_latch))
		else $error("Second toggle latch moved without a wrap.");
	a_compare_clock_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap[IDX_CORE_SECOND] |=> compare_clock_pulse ##1
		(compare_clock_pulse == $past(wrap[IDX_CORE_SECOND])))
		else $error("Compare clock pulse not one cycle after wrap.");
	a_reload_second_core: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_core2_wrap |=> s_reloaded)
		else $error("Second core not reloaded from capture register.");
	a_capture_copy_aux: assert property (
		@(posedge pclk) disable iff (!presetn)
		(cap_ev && !(wr_en && paddr == OFF_CAPTURE_RELOAD)) |=>
		capture_reload_register == $past(cnt[IDX_AUX_SECOND]))
		else $error("Capture did not copy auxiliary timer.");
	a_capture_clear_aux: assert property (
		@(posedge pclk) disable iff (!presetn)
		(cap_ev && cfg_reg[C_CLEAR] && !wr_cnt[IDX_AUX_SECOND]) |=>
		cnt[IDX_AUX_SECOND] == '0)
		else $error("Auxiliary timer not cleared after capture.");
	a_prescale_first_min: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tick[IDX_AUX_LOW] &&
		ctrl_reg[IDX_AUX_LOW][F_MODE_LO +: 3] == MODE_TIMER) |->
		pre_reg[2:0] == 3'h7)
		else $error("First module tick off the divide-by-8 grid.");
	a_prescale_second_min: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tick[IDX_CORE_SECOND] &&
		ctrl_reg[IDX_CORE_SECOND][F_MODE_LO +: 3] == MODE_TIMER) |->
		pre_reg[1:0] == 2'h3)
		else $error("Second module tick off the divide-by-4 grid.");
	a_stopped_no_count: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctrl_reg[IDX_AUX_HIGH][F_RUN] |-> !tick[IDX_AUX_HIGH])
		else $error("Stopped timer counted.");
endmodule

// File: tb/gptu_quad_model.sv
// Behavioural quadrature position sensor facing the timer unit pins.
`timescale 1ns/10ps
module gptu_quad_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic step,
	input wire logic fwd,
	input wire logic [3:0] hold,
	output logic quad_a,
	output logic quad_b,
	output logic busy,
	output logic sensor_zero_marker
);
	logic [1:0] phase_reg;
	logic [3:0] wait_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 2'h0;
			wait_reg <= 4'h0;
		end else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
		end else if (step) begin
			phase_reg <= fwd ? phase_reg + 2'h1 : phase_reg - 2'h1;
			wait_reg <= hold;
		end
	end
	// Signal A leads B when the shaft moves forward.
	assign quad_a = phase_reg == 2'h1 || phase_reg == 2'h2;
	assign quad_b = phase_reg[1];
	assign busy = wait_reg != 4'h0;
	assign sensor_zero_marker = phase_reg == 2'h0;
endmodule

// File: tb/test_general_purpose_timer_unit.sv
// Self-checking bench for the general purpose timer unit.
`timescale 1ns/10ps
`define CHK(nm, exv, gotv) \
	begin \
		samples_checked++; \
		if ((gotv) !== (exv)) begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", nm, exv, gotv); \
		end \
	end
module test_general_purpose_timer_unit;
	import gptu_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, lerr, tog1, tog2, ccp, qa, qb, qbusy;
	logic [4:0] cin = 0, dreg = 0;
	logic cap = 0, step = 0, fwd = 0;
	logic [3:0] hold = 0;
	int num_errors = 0, samples_checked = 0, cyc = 0, npulse = 0;
	int seed = 26527;
	wire [4:0] cpin = {cin[4:2], qa, cin[0]};
	wire [4:0] dpin = {dreg[4:2], qb, dreg[0]};
	gptu_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_gate_input_pin(cpin),
		.external_direction_pin(dpin), .capture_trigger_pin(cap),
		.toggle_output_pin(tog1), .second_core_toggle_pin(tog2),
		.compare_clock_pulse(ccp));
	gptu_quad_model partner (.pclk(pclk), .presetn(presetn),
		.step(step), .fwd(fwd), .hold(hold), .quad_a(qa), .quad_b(qb),
		.busy(qbusy), .sensor_zero_marker());
	// Clock and cycle count.
	initial begin
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (ccp === 1'b1) npulse <= npulse + 1;
	end
	function automatic logic [31:0] ctl(input int md, s, r, dn, ex, gl, ed);
		return 32'(s + 8 * md + 64 * r + 128 * dn + 256 * ex + 512 * gl
			+ 1024 * ed);
	endfunction
	function automatic logic [7:0] ca(input int i);
		return OFF_CTRL_BASE + 8'(4 * i);
	endfunction
	function automatic logic [7:0] na(input int i);
		return OFF_CNT_BASE + 8'(4 * i);
	endfunction
	task automatic results();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One APB transfer; ts is the cycle of its setup edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q, output int ts);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		ts = cyc;
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		if (k >= 64) num_errors++;
		q = prdata;
		lerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		int t;
		apb(1, a, d, q, t);
	endtask
	// Counter change between two reads dl cycles apart.
	task automatic span(input int i, input int dl, output logic [15:0] d);
		logic [31:0] a, b;
		int t, u;
		apb(0, na(i), 0, a, t);
		while (cyc < t + dl - 2) @(posedge pclk);
		apb(0, na(i), 0, b, u);
		d = b[15:0] - a[15:0];
	endtask
	// Sensor steps with a rest of h cycles after each.
	task automatic quad(input int n, input logic f, input logic [3:0] h);
		int k;
		repeat (n) begin
			@(posedge pclk);
			step <= 1;
			fwd <= f;
			hold <= h;
			@(posedge pclk);
			step <= 0;
			k = 0;
			do begin
				@(posedge pclk);
				k++;
			end while (qbusy && k < 20);
		end
	endtask
	// Watchdog against a hung run.
	initial begin
		#800000;
		num_errors++;
		results();
	end
	// Main sequence of scenarios.
	initial begin
		logic [31:0] q;
		logic [15:0] v, d, r;
		logic dn, ex, g;
		int idx, p, n, ts, e, t;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		apb(0, ca(0), 0, q, ts);
		`CHK("ctrl reset", 32'h0, q)
		`CHK("ready", 1'b1, pready)
		`CHK("mapped", 1'b0, lerr)
		apb(0, 8'h4c, 0, q, ts);
		`CHK("unmapped", 1'b1, lerr)
		for (int s = 0; s < 8; s++) begin
			for (int m = 0; m < 2; m++) begin
				idx = m ? 3 + {$random(seed)} % 2 : {$random(seed)} % 3;
				dn = 1'($random(seed));
				ex = 1'($random(seed));
				dreg[idx] <= 1'($random(seed));
				repeat (8) @(posedge pclk);
				g = dn ^ (ex & dpin[idx]);
				wr(na(idx), g ? 32'h0 : 32'hffff);
				wr(ca(idx), ctl(0, s, 1, dn, ex, 0, 0));
				p = (idx < 3 ? 8 : 4) << s;
				span(idx, 2 * p, d);
				`CHK("timer span", g ? 16'hfffe : 16'h0002, d)
				wr(ca(idx), 0);
			end
		end
		for (e = 1; e < 4; e++) begin
			idx = e == 1 ? 0 : e + 1;
			wr(na(idx), 0);
			wr(ca(idx), ctl(1, 0, 1, 0, 0, 0, e));
			n = 2 + {$random(seed)} % 6;
			repeat (n) begin
				cin[idx] <= 1;
				repeat (4) @(posedge pclk);
				cin[idx] <= 0;
				repeat (4) @(posedge pclk);
			end
			repeat (8) @(posedge pclk);
			apb(0, na(idx), 0, q, ts);
			`CHK("events", 16'(e == 3 ? 2 * n : n), q[15:0])
			wr(ca(idx), 0);
		end
		idx = 3 * ({$random(seed)} % 2);
		g = 1'($random(seed));
		cin[idx] <= g;
		wr(na(idx), 0);
		wr(ca(idx), ctl(2, 0, 1, 0, 0, g, 0));
		repeat (8) @(posedge pclk);
		span(idx, 16, d);
		`CHK("gate shut", 16'h0, d)
		cin[idx] <= ~g;
		repeat (8) @(posedge pclk);
		span(idx, idx ? 16 : 32, d);
		`CHK("gate open", 16'h4, d)
		wr(ca(idx), 0);
		wr(na(1), 0);
		wr(ca(1), ctl(3, 0, 1, 0, 0, 0, 0));
		n = 3 + {$random(seed)} % 8;
		quad(n, 1, 3);
		quad(2, 0, 9);
		repeat (8) @(posedge pclk);
		apb(0, na(1), 0, q, ts);
		`CHK("position", 16'(n - 2), q[15:0])
		for (e = 0; e < 2; e++) begin
			v = 16'($random(seed));
			wr(na(3), {16'h0, v});
			wr(OFF_CAPCFG, 32'(1 + 4 * e));
			cap <= 1;
			repeat (8) @(posedge pclk);
			apb(0, OFF_CAPTURE_RELOAD, 0, q, ts);
			`CHK("capture", v, q[15:0])
			apb(0, na(3), 0, q, ts);
			`CHK("clear", e ? 16'h0 : v, q[15:0])
			cap <= 0;
			repeat (8) @(posedge pclk);
		end
		wr(OFF_CAPCFG, 32'h8);
		v = 16'($random(seed));
		wr(na(3), {16'h0, v});
		// Two steps move signal A exactly once, whatever the phase.
		quad(2, 1, 3);
		repeat (8) @(posedge pclk);
		apb(0, OFF_CAPTURE_RELOAD, 0, q, ts);
		`CHK("pin capture", v, q[15:0])
		// Two steps move signal B exactly once as well.
		wr(OFF_CAPCFG, 32'h10);
		v = 16'($random(seed));
		wr(na(3), {16'h0, v});
		quad(2, 0, 3);
		repeat (8) @(posedge pclk);
		apb(0, OFF_CAPTURE_RELOAD, 0, q, ts);
		`CHK("dir capture", v, q[15:0])
		// first core wrap clocks the low aux and reloads from the high aux.
		r = 16'($random(seed)) & 16'h0fff;
		wr(na(0), 0);
		wr(ca(0), ctl(6, 0, 1, 0, 0, 0, 3));
		wr(na(2), {16'h0, r});
		wr(ca(2), ctl(4, 0, 1, 0, 0, 0, 0));
		wr(na(1), 32'hfffc);
		g = tog1;
		wr(ca(1), ctl(0, 0, 1, 0, 0, 0, 0));
		repeat (64) @(posedge pclk);
		wr(ca(1), 0);
		`CHK("latch one", ~g, tog1)
		apb(0, OFF_STATUS, 0, q, ts);
		`CHK("status", ~g, q[0])
		apb(0, na(0), 0, q, ts);
		`CHK("chained", 16'h1, q[15:0])
		apb(0, na(1), 0, q, ts);
		d = q[15:0] - r;
		`CHK("reload one", 1'b1, d < 16'h10)
		// The stopped core is captured by the high aux on its pin edge.
		v = q[15:0];
		wr(ca(2), ctl(5, 0, 1, 0, 0, 0, 1));
		cin[2] <= 1;
		repeat (8) @(posedge pclk);
		apb(0, na(2), 0, q, ts);
		`CHK("capture core", v, q[15:0])
		// second core wrap toggles, clocks, reloads.
		r = 16'($random(seed)) & 16'h0fff;
		wr(OFF_CAPCFG, 32'h20);
		wr(OFF_CAPTURE_RELOAD, {16'h0, r});
		wr(na(3), 0);
		wr(ca(3), ctl(6, 0, 1, 0, 0, 0, 3));
		wr(na(4), 32'hfffc);
		g = tog2;
		t = npulse;
		wr(ca(4), ctl(0, 0, 1, 0, 0, 0, 0));
		repeat (32) @(posedge pclk);
		wr(ca(4), 0);
		`CHK("latch two", ~g, tog2)
		`CHK("compare clock", 1, npulse - t)
		apb(0, na(3), 0, q, ts);
		`CHK("aux two", 16'h1, q[15:0])
		apb(0, na(4), 0, q, ts);
		d = q[15:0] - r;
		`CHK("reload two", 1'b1, d < 16'h10)
		results();
	end
endmodule
